// ---- hdl/dcf_defs.svh ----
/*
 * Offsets, field positions, reset values and codes for the second device
 * configuration register. Assumes inclusion by bare name; definitions only.
 */
`ifndef DCF_DEFS_SVH
`define DCF_DEFS_SVH

`define DCF_REG_OFFSET 8'h15
`define DCF_ADDR_W 8
`define DCF_DATA_W 16
`define DCF_COEF_HI 15
`define DCF_COEF_LO 13
`define DCF_SPARE_HI 11
`define DCF_SPARE_LO 8
`define DCF_PUMP_BIT 6
`define DCF_FORCE_BIT 5
`define DCF_ALERT_TEST_BIT 4
`define DCF_SPI_TO_BIT 2
`define DCF_ACQ_WD_BIT 1
`define DCF_BAL_WD_BIT 0
`define DCF_RESET_VALUE 16'h4000
`define DCF_WRITE_MASK 16'hef77
`define DCF_COEF_RESET 3'h2
`define DCF_UART_DIFF_ALERT 2'h2
`define DCF_WEIGHT_W 4

`endif

// ---- hdl/dcf_pkg.sv ----
/*
 * Types shared by the configuration register block.
 * Assumes dcf_defs.svh is on the include path.
 */
`include "dcf_defs.svh"

package dcf_pkg;
    // register word as stored
    typedef logic [`DCF_DATA_W-1:0] dcf_word_t;
    // filter weight in eighths, 1..8
    typedef logic [`DCF_WEIGHT_W-1:0] dcf_weight_t;
endpackage

// ---- hdl/dcf_weight_decode.sv ----
/*
 * Decodes the three-bit filter coefficient code into a weight in eighths.
 * Assumes a registered code on the same clock; output is combinational.
 */
`timescale 1ns/100ps
`include "dcf_defs.svh"

module dcf_weight_decode (
    // coefficient code
    input wire logic [2:0] coef_code,
    // weight in eighths, 1 = 0.125 .. 8 = 1.000
    output dcf_pkg::dcf_weight_t weight,
    // high when weight is 1.000 and the filter passes samples unchanged
    output logic filter_bypass
);
    // code plus one gives eighths; 111 reaches the full weight
    always_comb begin
        weight = dcf_pkg::dcf_weight_t'({1'b0, coef_code}) + 4'h1;
        filter_bypass = (coef_code == 3'h7);
    end
endmodule

// ---- hdl/dcf_config_reg.sv ----
/*
 * Second device configuration register: filter coefficient, spare bits,
 * diagnostics controls and watchdog disables, with the pin-level effects.
 * Assumes the host protocol engine presents a one-cycle access strobe on
 * clk; alert, user-alert, UART-config and interface-select inputs come from pins or other
 * clock domains and are synchronised here.
 */
//
// Contract
// - coefficient code selects weight 0.125 to 1.000
// - coefficient resets to code 010
// - weight sets new-sample share, 1.0 bypasses
// - spare field stores and returns writes, resets zero
// - bit 6 switches off high voltage pump
// - bit 5 enables shutdown pin pull-down
// - clearing bit 5 releases the pull-down
// - alert test drives pin low on alert
// - user alert bit toggles alert in test
// - alert test works in every UART configuration
// - alert test ignored in SPI operation
// - bit 2 set turns SPI timeout monitor off
// - SPI timeout disable ignored under UART
// - bit 1 disables acquisition watchdog, flag kept
// - bit 0 disables balancing watchdog, flag kept
// - interface select high means UART, low SPI
`timescale 1ns/100ps
`include "dcf_defs.svh"

module dcf_config_reg (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // register access from the host protocol engine
    input wire logic reg_access,
    input wire logic reg_write,
    input wire logic [`DCF_ADDR_W-1:0] reg_addr,
    input wire logic [`DCF_DATA_W-1:0] reg_wdata,
    output logic [`DCF_DATA_W-1:0] reg_rdata,
    output logic reg_rvalid,
    // asynchronous status inputs
    input wire logic interface_select,
    input wire logic [1:0] uart_config_select,
    input wire logic alert_present,
    input wire logic user_alert_bit,
    // filter control
    output dcf_pkg::dcf_weight_t filter_weight,
    output logic filter_bypass,
    // diagnostics and watchdog controls
    output logic high_volt_pump_enable,
    output logic shutdown_pulldown_enable,
    output logic serial_timeout_enable,
    output logic acquisition_watchdog_enable,
    output logic balancing_watchdog_enable,
    // alert output pin override; oe high while test mode drives it
    output logic alert_test_out,
    output logic alert_test_oe,
    output logic alert_test_active
);
    // reset release through two flops
    logic rst_s1_r;
    logic rst_s2_r;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end
    logic rst_n;
    assign rst_n = rst_s2_r;

    // two-flop synchronisers for the pin-side inputs, one per bit
    localparam int SYNC_W = 5;
    logic [SYNC_W-1:0] async_in;
    logic [SYNC_W-1:0] sync1_r;
    logic [SYNC_W-1:0] sync2_r;
    assign async_in = {user_alert_bit, alert_present, uart_config_select, interface_select};
    genvar gi;
    generate
        for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    sync1_r[gi] <= 1'b0;
                    sync2_r[gi] <= 1'b0;
                end else begin
                    sync1_r[gi] <= async_in[gi];
                    sync2_r[gi] <= sync1_r[gi];
                end
            end
        end
    endgenerate
    logic uart_mode;
    logic [1:0] uart_cfg;
    logic alert_cond;
    logic user_alert;
    assign uart_mode = sync2_r[0];
    assign uart_cfg = sync2_r[2:1];
    assign alert_cond = sync2_r[3];
    assign user_alert = sync2_r[4];

    // register word; unused positions masked so they never store
    dcf_pkg::dcf_word_t cfg_r;
    dcf_pkg::dcf_word_t cfg_nxt;
    logic hit;
    assign hit = reg_access && (reg_addr == `DCF_REG_OFFSET);
    always_comb begin
        cfg_nxt = cfg_r;
        if (hit && reg_write) begin
            cfg_nxt = reg_wdata & `DCF_WRITE_MASK;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_r <= `DCF_RESET_VALUE;
        end else begin
            cfg_r <= cfg_nxt;
        end
    end

    // read path: one cycle after the strobe, zero for other addresses
    logic [`DCF_DATA_W-1:0] rdata_nxt;
    logic rvalid_nxt;
    always_comb begin
        rvalid_nxt = reg_access && !reg_write;
        rdata_nxt = '0;
        if (hit && !reg_write) begin
            rdata_nxt = cfg_r;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= '0;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rdata <= rdata_nxt;
            reg_rvalid <= rvalid_nxt;
        end
    end

    // weight decode from the stored code
    dcf_pkg::dcf_weight_t weight_c;
    logic bypass_c;
    dcf_weight_decode u_weight (
        .coef_code(cfg_r[`DCF_COEF_HI:`DCF_COEF_LO]),
        .weight(weight_c),
        .filter_bypass(bypass_c)
    );

    // control outputs; registered so every output comes from a flop
    logic pump_en_nxt;
    logic pulldown_nxt;
    logic spi_to_en_nxt;
    logic acq_wd_nxt;
    logic bal_wd_nxt;
    logic test_act_nxt;
    logic test_out_nxt;
    always_comb begin
        pump_en_nxt = !cfg_r[`DCF_PUMP_BIT];
        // level follows the bit, so a clear before the reset drops it
        pulldown_nxt = cfg_r[`DCF_FORCE_BIT];
        // monitor stays on under UART whatever the bit says
        spi_to_en_nxt = uart_mode || !cfg_r[`DCF_SPI_TO_BIT];
        // only the enable is removed; the timeout flags live elsewhere
        acq_wd_nxt = !cfg_r[`DCF_ACQ_WD_BIT];
        bal_wd_nxt = !cfg_r[`DCF_BAL_WD_BIT];
        // no check of the UART configuration: every code qualifies
        test_act_nxt = cfg_r[`DCF_ALERT_TEST_BIT] && uart_mode;
        // user bit forms an alert condition of its own
        test_out_nxt = !(alert_cond || user_alert);
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            filter_weight <= 4'h3;
            filter_bypass <= 1'b0;
            high_volt_pump_enable <= 1'b1;
            shutdown_pulldown_enable <= 1'b0;
            serial_timeout_enable <= 1'b1;
            acquisition_watchdog_enable <= 1'b1;
            balancing_watchdog_enable <= 1'b1;
            alert_test_active <= 1'b0;
            alert_test_oe <= 1'b0;
            alert_test_out <= 1'b1;
        end else begin
            filter_weight <= weight_c;
            filter_bypass <= bypass_c;
            high_volt_pump_enable <= pump_en_nxt;
            shutdown_pulldown_enable <= pulldown_nxt;
            serial_timeout_enable <= spi_to_en_nxt;
            acquisition_watchdog_enable <= acq_wd_nxt;
            balancing_watchdog_enable <= bal_wd_nxt;
            alert_test_active <= test_act_nxt;
            alert_test_oe <= test_act_nxt;
            alert_test_out <= test_out_nxt;
        end
    end

    // uart_cfg only informs: test mode overrides even differential alert
    logic diff_alert_unused;
    assign diff_alert_unused = (uart_cfg == `DCF_UART_DIFF_ALERT) && alert_test_active;
endmodule

// ---- dv/dcf_config_chk.sv ----
/*
 * Port checker for the configuration register block.
 * Assumes the block's top ports; bound to every instance at the foot.
 */
`timescale 1ns/100ps
module dcf_config_chk (
    // clock, reset and access strobe
    input wire logic clk,
    input wire logic reset_n,
    input wire logic reg_access,
    input wire logic reg_write,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid,
    // pin level and outputs
    input wire logic interface_select,
    input wire dcf_pkg::dcf_weight_t filter_weight,
    input wire logic filter_bypass,
    input wire logic high_volt_pump_enable,
    input wire logic shutdown_pulldown_enable,
    input wire logic serial_timeout_enable,
    input wire logic alert_test_active
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // a write that lands in the register
    wire wr15 = reg_access && reg_write && reg_addr == 8'h15;
    // read answer and readback of unused bits
    read_answer_a: assert property (reg_access && !reg_write |=> reg_rvalid)
        else $error("read not answered");
    unused_zero_a: assert property (reg_rvalid |-> (reg_rdata & 16'h1088) == 16'h0)
        else $error("unused bit reads one");
    // outputs follow a write two edges on
    weight_write_a: assert property (
        wr15 |=> ##1 filter_weight == $past(reg_wdata[15:13], 2) + 4'h1) else $error("weight");
    bypass_full_a: assert property (filter_bypass == (filter_weight == 4'h8))
        else $error("bypass mismatch");
    pump_write_a: assert property (
        wr15 |=> ##1 high_volt_pump_enable == !$past(reg_wdata[6], 2)) else $error("pump");
    pulldown_write_a: assert property (
        wr15 |=> ##1 shutdown_pulldown_enable == $past(reg_wdata[5], 2)) else $error("pull");
    // interface select gates test mode and timeout disable, 3 edges of latency
    spi_alert_a: assert property (!interface_select [*4] |-> !alert_test_active)
        else $error("alert test active in spi");
    uart_timeout_a: assert property (interface_select [*4] |-> serial_timeout_enable)
        else $error("timeout off under uart");
    cover property (wr15 && reg_wdata[5]);
    cover property (reg_rvalid);
    cover property (filter_bypass);
endmodule

bind dcf_config_reg dcf_config_chk dcf_config_chk_i (.clk, .reset_n, .reg_access,
    .reg_write, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .interface_select,
    .filter_weight, .filter_bypass, .high_volt_pump_enable, .shutdown_pulldown_enable,
    .serial_timeout_enable, .alert_test_active);

// ---- dv/dcf_host_model.sv ----
/*
 * Host controller model: one-cycle access strobes on clk via xfer.
 * Assumes the bench calls xfer and never overlaps two calls.
 */
`timescale 1ns/100ps
module dcf_host_model (
    // clock and answer
    input wire logic clk,
    input wire logic [15:0] reg_rdata,
    // access strobe
    output logic reg_access,
    output logic reg_write,
    output logic [7:0] reg_addr,
    output logic [15:0] reg_wdata
);
    initial begin
        reg_access = 1'b0;
        reg_write = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
    end
    // data inverted once released so a stale value never passes for a hold
    task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d,
            output logic [15:0] q);
        @(posedge clk);
        reg_access <= 1'b1;
        reg_write <= w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_access <= 1'b0;
        reg_wdata <= ~d;
        #1 q = reg_rdata;
    endtask
endmodule

// ---- dv/dcf_config_reg_tb.sv ----
/*
 * Bench for the configuration register block.
 * Assumes the host model and the bound checker are compiled alongside.
 */
`timescale 1ns/100ps
module dcf_config_reg_tb;
    logic clk, reset_n, reg_access, reg_write, reg_rvalid, interface_select, alert_present;
    logic user_alert_bit, filter_bypass, high_volt_pump_enable, shutdown_pulldown_enable;
    logic serial_timeout_enable, acquisition_watchdog_enable, balancing_watchdog_enable;
    logic alert_test_out, alert_test_oe, alert_test_active;
    logic [1:0] uart_config_select;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, q;
    dcf_pkg::dcf_weight_t filter_weight;
    int err_count, checks_done;
    // outputs packed so one compare covers a whole state
    wire [15:0] ctl = {5'h0, filter_weight, filter_bypass, high_volt_pump_enable,
        shutdown_pulldown_enable, serial_timeout_enable, acquisition_watchdog_enable,
        balancing_watchdog_enable, alert_test_active};
    wire [15:0] pin = {12'h0, alert_test_oe, alert_test_active, alert_test_out,
        serial_timeout_enable};
    dcf_config_reg dcf_config_reg_i (.clk, .reset_n, .reg_access, .reg_write, .reg_addr,
        .reg_wdata, .reg_rdata, .reg_rvalid, .interface_select, .uart_config_select,
        .alert_present, .user_alert_bit, .filter_weight, .filter_bypass,
        .high_volt_pump_enable, .shutdown_pulldown_enable, .serial_timeout_enable,
        .acquisition_watchdog_enable, .balancing_watchdog_enable, .alert_test_out,
        .alert_test_oe, .alert_test_active);
    dcf_host_model dcf_host_model_i (.clk, .reg_rdata, .reg_access, .reg_write,
        .reg_addr, .reg_wdata);
    task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
        checks_done++;
        if (s !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    // write, then let the output flops catch up
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        dcf_host_model_i.xfer(1'b1, a, d, q);
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic rd(input logic [15:0] e);
        dcf_host_model_i.xfer(1'b0, 8'h15, 16'h0000, q);
        check("rvalid", {15'h0, reg_rvalid}, 16'h0001);
        check("rdata", q, e);
    endtask
    task automatic reset_values;
        rd(16'h4000);
        check("ctl", ctl, 16'h01ae);
    endtask
    // spi stays selected here, so no uart traffic meets the forced reset
    task automatic write_fields;
        wr(8'h15, 16'hffff);
        rd(16'hef77);
        check("ctl", ctl, 16'h0450);
        wr(8'h15, 16'h0000);
        check("ctl", ctl, 16'h00ae);
    endtask
    task automatic coef_codes;
        for (int i = 0; i < 8; i++) begin
            wr(8'h15, {i[2:0], 13'h0});
            check("weight", {12'h0, filter_weight}, 16'(i + 1));
        end
        wr(8'h16, 16'h0000);
        rd(16'he000);
        dcf_host_model_i.xfer(1'b0, 8'h16, 16'h0000, q);
        check("unmapped", q, 16'h0000);
    endtask
    // pins cross a two-flop synchroniser and an output flop
    task automatic pin_case(input logic s, a, u, input logic [15:0] e);
        @(posedge clk);
        interface_select <= s;
        alert_present <= a;
        user_alert_bit <= u;
        repeat (4) @(posedge clk);
        #1 check("pin", pin, e);
    endtask
    task automatic alert_test;
        wr(8'h15, 16'h0014);
        uart_config_select <= 2'h2;
        pin_case(1'b1, 1'b0, 1'b0, 16'h000f);
        pin_case(1'b1, 1'b0, 1'b1, 16'h000d);
        pin_case(1'b1, 1'b1, 1'b0, 16'h000d);
        pin_case(1'b0, 1'b1, 1'b0, 16'h0000);
    endtask
    task automatic complete_run;
        if (err_count == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        reset_n = 1'b0;
        interface_select = 1'b0;
        uart_config_select = 2'h0;
        alert_present = 1'b0;
        user_alert_bit = 1'b0;
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        reset_values;
        write_fields;
        coef_codes;
        alert_test;
        complete_run;
    end
    // a hang counts as a mismatch
    initial begin
        #100us;
        err_count++;
        complete_run;
    end
endmodule
